/* include/bpsc_pkg.sv */
// package for the bridge power state control block
package bpsc_pkg;
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_SLOT   = 8'h08;
   localparam int CTRL_PSTATE_LSB = 0;
   localparam int CTRL_WAKE_EN    = 8;
   localparam int CTRL_INIT_DONE  = 9;
   localparam int CTRL_CLKRUN_OK  = 10;
   localparam int SLOT_VCC_LSB    = 0;
   localparam logic [1:0] PST_D0 = 2'h0;
   localparam logic [1:0] PST_D1 = 2'h1;
   localparam logic [1:0] PST_D2 = 2'h2;
   localparam logic [1:0] PST_D3 = 2'h3;
   localparam logic [2:0] SLOT_VCC_RST = 3'h0;
   localparam int WARM_RST_CYCLES = 16;
   typedef enum logic [2:0] {
      BPSC_D0_UNINIT = 3'b000,
      BPSC_D0_ACTIVE = 3'b001,
      BPSC_D1        = 3'b010,
      BPSC_D2        = 3'b011,
      BPSC_D3HOT     = 3'b100,
      BPSC_WARM_RST  = 3'b101
   } bpsc_state_t;
endpackage

/* rtl/bpsc_top.sv */
// power state control for a pci bridge to a card socket, apb registers
// Operation
// - state changes only by software, reset forces uninit
// - only listed transitions are taken
// - slot supply off in uninit D0
// - host clock runs unless clock-run stops it
// - no interrupts in uninitialized D0
// - uninit D0 reports card detect and type
// - wake enabled: keep wake context, supply kept
// - config cycles answered in uninitialized D0
// - card clock runs in active D0; code stops it with the host clock under clock-run
// - card interrupts and socket change delivered
// - wake event signal available when enabled
// - active D0 supply changes only by software or on removal
// - pci interrupts delivered in active D0
// - full context readable in active D0
// - all cycles answered in active D0
// - D3hot to D0 does internal warm reset
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
module bpsc_top
   import bpsc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        wake_from_aux,
   input  wire logic        card_present,
   input  wire logic [1:0]  card_type,
   input  wire logic        clkrun_stop,
   input  wire logic        card_irq,
   input  wire logic        socket_change_interrupt,
   input  wire logic        card_wake,
   output logic             host_clk_en,
   output logic             card_clk_en,
   output logic             irq_out,
   output logic             wake_event,
   output logic [2:0]       slot_vcc,
   output logic             cfg_only,
   output logic             full_decode,
   output logic             drivers_off
);
   typedef struct packed {
      bpsc_state_t st;
      logic        wake_en;
      logic        clkrun_ok;
      logic [2:0]  vcc;
      logic [4:0]  wcnt;
      logic [2:0]  pres_s;
      logic        card_q;
      logic [2:0]  aux_s;
      logic        aux_q;
      logic [31:0] rdata;
   } bpsc_regs_t;

   bpsc_regs_t r_q, r_d;
   logic        wr, rd, present, removed;
   logic [1:0]  pfield;
   logic [1:0]  req;
   logic        init_flag;

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   // 2nd and 3rd stage agree before the card counts as present or gone
   assign present = (r_q.pres_s[1] == r_q.pres_s[2]) ? r_q.pres_s[2] : r_q.card_q;
   assign removed = r_q.card_q & ~present;
   assign req = pwdata[CTRL_PSTATE_LSB +: 2];
   assign init_flag = (r_q.st != BPSC_D0_UNINIT) && (r_q.st != BPSC_WARM_RST);

   always_comb begin
      case (r_q.st)
         BPSC_D0_UNINIT, BPSC_D0_ACTIVE, BPSC_WARM_RST: pfield = PST_D0;
         BPSC_D1:                                      pfield = PST_D1;
         BPSC_D2:                                      pfield = PST_D2;
         default:                                      pfield = PST_D3;
      endcase
   end

   always_comb begin
      r_d = r_q;
      r_d.pres_s = {r_q.pres_s[1:0], card_present};
      r_d.card_q = present;
      r_d.aux_s  = {r_q.aux_s[1:0], wake_from_aux};
      if (r_q.aux_s[1] == r_q.aux_s[2]) begin
         r_d.aux_q = r_q.aux_s[2];
      end
      if (r_q.st == BPSC_WARM_RST) begin
         r_d.wcnt = r_q.wcnt + 5'h1;
         if (r_q.wcnt == 5'(WARM_RST_CYCLES - 1)) begin
            r_d.st = BPSC_D0_UNINIT;
            // soft reset drops all context but the wake part
            r_d.clkrun_ok = 1'b0;
         end
      end else if (wr && paddr == ADDR_CTRL) begin
         r_d.wake_en   = pwdata[CTRL_WAKE_EN];
         r_d.clkrun_ok = pwdata[CTRL_CLKRUN_OK];
         // only software writes move the state
         case (r_q.st)
            BPSC_D0_UNINIT: begin
               if (req == PST_D0 && pwdata[CTRL_INIT_DONE]) begin
                  r_d.st = BPSC_D0_ACTIVE;
               end else if (req == PST_D3) begin
                  r_d.st = BPSC_D3HOT;
               end
            end
            BPSC_D0_ACTIVE: begin
               if (req == PST_D1) begin
                  r_d.st = BPSC_D1;
               end else if (req == PST_D2) begin
                  r_d.st = BPSC_D2;
               end else if (req == PST_D3) begin
                  r_d.st = BPSC_D3HOT;
               end
            end
            BPSC_D1: begin
               if (req == PST_D0) begin
                  r_d.st = BPSC_D0_ACTIVE;
               end else if (req == PST_D2) begin
                  r_d.st = BPSC_D2;
               end else if (req == PST_D3) begin
                  r_d.st = BPSC_D3HOT;
               end
            end
            BPSC_D2: begin
               if (req == PST_D0) begin
                  r_d.st = BPSC_D0_ACTIVE;
               end else if (req == PST_D3) begin
                  r_d.st = BPSC_D3HOT;
               end
            end
            BPSC_D3HOT: begin
               if (req == PST_D0) begin
                  r_d.st   = BPSC_WARM_RST;
                  r_d.wcnt = 5'h0;
               end
            end
            default: r_d.st = BPSC_D0_UNINIT;
         endcase
      end
      // supply moves only by software in active D0, off on removal
      if (wr && paddr == ADDR_SLOT && r_q.st == BPSC_D0_ACTIVE && present) begin
         r_d.vcc = pwdata[SLOT_VCC_LSB +: 3];
      end
      if (removed) begin
         r_d.vcc = SLOT_VCC_RST;
      end
      // uninit without wake: supply off
      // aux-held wake path keeps the applied supply; removal still drops it
      if (r_q.st == BPSC_D0_UNINIT && !r_q.wake_en && !r_q.aux_q) begin
         r_d.vcc = SLOT_VCC_RST;
      end
      // config space always readable in D0 states
      r_d.rdata = 32'h0000_0000;
      if (rd) begin
         case (paddr)
            ADDR_CTRL: begin
               r_d.rdata[CTRL_PSTATE_LSB +: 2] = pfield;
               r_d.rdata[CTRL_WAKE_EN]   = r_q.wake_en;
               r_d.rdata[CTRL_INIT_DONE] = init_flag;
               r_d.rdata[CTRL_CLKRUN_OK] = r_q.clkrun_ok;
            end
            ADDR_STATUS: r_d.rdata = {29'h0000_0000, card_type, present};
            ADDR_SLOT:   r_d.rdata = {29'h0000_0000, r_q.vcc};
            default:     r_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         r_q.st        <= BPSC_D0_UNINIT;
         r_q.wake_en   <= 1'b0;
         r_q.clkrun_ok <= 1'b0;
         r_q.vcc       <= SLOT_VCC_RST;
         r_q.wcnt      <= 5'h0;
         r_q.pres_s    <= 3'h0;
         r_q.card_q    <= 1'b0;
         r_q.aux_s     <= 3'h0;
         r_q.aux_q     <= 1'b0;
         r_q.rdata     <= 32'h0000_0000;
      end else begin
         r_q <= r_d;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & (paddr != ADDR_CTRL) & (paddr != ADDR_STATUS)
                    & (paddr != ADDR_SLOT);
   assign prdata  = r_q.rdata;
   assign slot_vcc = r_q.vcc;
   // without clock-run the host clock stays on, and the card clock stays on in active D0
   assign host_clk_en = ~(r_q.clkrun_ok & clkrun_stop);
   assign card_clk_en = (r_q.st == BPSC_D0_ACTIVE) ? ~(r_q.clkrun_ok & clkrun_stop) : 1'b0;
   // interrupts only in active D0
   assign irq_out = (r_q.st == BPSC_D0_ACTIVE) & (card_irq | socket_change_interrupt);
   assign wake_event = r_q.wake_en & card_wake & (r_q.st != BPSC_WARM_RST);
   assign cfg_only    = (r_q.st != BPSC_D0_ACTIVE) & (r_q.st != BPSC_WARM_RST);
   assign full_decode = (r_q.st == BPSC_D0_ACTIVE);
   assign drivers_off = (r_q.st == BPSC_WARM_RST);

   // multi-step arcs are built from these
   sequence s_ctrl_wr;
      wr && paddr == ADDR_CTRL;
   endsequence

   sequence s_d3_exit;
      r_q.st == BPSC_D3HOT ##0 s_ctrl_wr ##0 req == PST_D0;
   endsequence

   sequence s_go_active;
      r_q.st == BPSC_D0_UNINIT ##0 s_ctrl_wr ##0 (req == PST_D0 && pwdata[CTRL_INIT_DONE]);
   endsequence

   sequence s_warm_done;
      r_q.st == BPSC_WARM_RST ##0 r_q.wcnt == 5'(WARM_RST_CYCLES - 1);
   endsequence

   // all on clk; reset aborts every one but the first
   a_rst_uninit: assert property (@(posedge clk) $rose(nrst) |-> r_q.st == BPSC_D0_UNINIT)
      else $error("not uninit after reset");

   a_no_self_move: assert property (@(posedge clk) disable iff (!nrst)
      !(wr && paddr == ADDR_CTRL) && r_q.st != BPSC_WARM_RST |=> $stable(r_q.st))
      else $error("state moved without software");

   a_uninit_arcs: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D0_UNINIT |=> r_q.st inside {BPSC_D0_UNINIT, BPSC_D0_ACTIVE, BPSC_D3HOT})
      else $error("illegal arc from uninit");

   a_active_arcs: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D0_ACTIVE |=> r_q.st != BPSC_D0_UNINIT && r_q.st != BPSC_WARM_RST)
      else $error("illegal arc from active");

   a_d1_arcs: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D1 |=> r_q.st inside {BPSC_D1, BPSC_D2, BPSC_D0_ACTIVE, BPSC_D3HOT})
      else $error("illegal arc from d1");

   a_d2_arcs: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D2 |=> r_q.st inside {BPSC_D2, BPSC_D0_ACTIVE, BPSC_D3HOT})
      else $error("illegal arc from d2");

   a_d3_arcs: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D3HOT |=> r_q.st == BPSC_D3HOT || r_q.st == BPSC_WARM_RST)
      else $error("illegal arc from d3");

   a_go_active: assert property (@(posedge clk) disable iff (!nrst)
      s_go_active |=> r_q.st == BPSC_D0_ACTIVE && init_flag)
      else $error("init write ignored");

   a_vcc_off_uninit: assert property (@(posedge clk) disable iff (!nrst)
      (r_q.st == BPSC_D0_UNINIT && !r_q.wake_en && !r_q.aux_q) ##1 (r_q.st == BPSC_D0_UNINIT)
      |-> slot_vcc == SLOT_VCC_RST)
      else $error("slot supply on in uninit");

   a_host_clk_on: assert property (@(posedge clk) disable iff (!nrst)
      !r_q.clkrun_ok |-> host_clk_en)
      else $error("host clock stopped");

   a_no_irq_uninit: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D0_UNINIT |-> !irq_out)
      else $error("irq in uninit");

   a_status_valid: assert property (@(posedge clk) disable iff (!nrst)
      rd && paddr == ADDR_STATUS |=> prdata[2:0] == {$past(card_type), $past(present)})
      else $error("status read wrong");

   a_wake_keep: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_WARM_RST && r_q.wake_en |=> r_q.wake_en)
      else $error("wake context lost");

   a_cfg_uninit: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D0_UNINIT |-> cfg_only && !full_decode)
      else $error("uninit decode wrong");

   a_slverr_map: assert property (@(posedge clk) disable iff (!nrst)
      psel && penable && paddr == ADDR_STATUS |-> pready && !pslverr)
      else $error("mapped access refused");

   a_card_clk_on: assert property (@(posedge clk) disable iff (!nrst)
      (r_q.st == BPSC_D0_ACTIVE && !clkrun_stop) |-> card_clk_en)
      else $error("card clock off");

   a_irq_active: assert property (@(posedge clk) disable iff (!nrst)
      (r_q.st == BPSC_D0_ACTIVE && socket_change_interrupt) |-> irq_out)
      else $error("interrupt lost");

   a_wake_avail: assert property (@(posedge clk) disable iff (!nrst)
      (r_q.st == BPSC_D0_ACTIVE && r_q.wake_en && card_wake) |-> wake_event)
      else $error("wake not passed");

   a_vcc_hold: assert property (@(posedge clk) disable iff (!nrst)
      (r_q.st == BPSC_D0_ACTIVE && !(wr && paddr == ADDR_SLOT) && !removed)
      |=> $stable(slot_vcc))
      else $error("supply changed");

   a_removal_off: assert property (@(posedge clk) disable iff (!nrst)
      removed |=> slot_vcc == SLOT_VCC_RST)
      else $error("supply kept after removal");

   a_irq_card: assert property (@(posedge clk) disable iff (!nrst)
      (r_q.st == BPSC_D0_ACTIVE && card_irq) |-> irq_out)
      else $error("card interrupt lost");

   a_ctrl_read: assert property (@(posedge clk) disable iff (!nrst)
      rd && paddr == ADDR_CTRL |=> prdata[1:0] == $past(pfield)
      && prdata[CTRL_WAKE_EN] == $past(r_q.wake_en))
      else $error("control read wrong");

   a_full_decode: assert property (@(posedge clk) disable iff (!nrst)
      full_decode == (pfield == PST_D0 && init_flag))
      else $error("decode mismatch");

   a_cfg_active: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D0_ACTIVE |-> full_decode && !cfg_only)
      else $error("active decode wrong");

   a_d3_to_warm: assert property (@(posedge clk) disable iff (!nrst)
      s_d3_exit |=> r_q.st == BPSC_WARM_RST)
      else $error("d3 exit without warm reset");

   a_warm_rst: assert property (@(posedge clk) disable iff (!nrst)
      $rose(r_q.st == BPSC_WARM_RST) |-> ##16 r_q.st == BPSC_D0_UNINIT)
      else $error("warm reset length");

   a_warm_quiet: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_WARM_RST |-> drivers_off && !card_clk_en && !irq_out)
      else $error("drivers active in warm reset");

   a_warm_clean: assert property (@(posedge clk) disable iff (!nrst)
      s_warm_done |=> r_q.st == BPSC_D0_UNINIT && !r_q.clkrun_ok)
      else $error("context kept by warm reset");

   a_field_d3: assert property (@(posedge clk) disable iff (!nrst)
      r_q.st == BPSC_D3HOT |-> pfield == PST_D3)
      else $error("state field wrong");
endmodule

/* tb/bpsc_host.sv */
// apb host model standing in for the system configuration software
`timescale 1ns/1ns
module bpsc_host (
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel = 1'b0,
   output logic             penable = 1'b0,
   output logic             pwrite = 1'b0,
   output logic [7:0]       paddr = 8'h00,
   output logic [31:0]      pwdata = 32'h0000_0000,
   output logic             hung = 1'b0
);
   // request stays put until pready is seen high; the bound only catches a dead slave
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (n = 0; n < 40 && pready !== 1'b1; n++) @(posedge clk);
      hung = (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the bridge power state control block
`timescale 1ns/1ns
module tb;
   import bpsc_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, card_present = 1'b1, clkrun_stop = 1'b1;
   logic        card_irq = 1'b1, card_wake = 1'b0, socket_change_interrupt = 1'b0;
   logic        wake_from_aux = 1'b0, psel, penable, pwrite, pready, pslverr, err, hung;
   logic        host_clk_en, card_clk_en, irq_out, wake_event, cfg_only, full_decode;
   logic        drivers_off;
   logic [1:0]  card_type = 2'h0;
   logic [2:0]  slot_vcc, sv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, obs, exp_q[$];
   int          num_errors = 0, checks = 0;
   event        shot;
   bpsc_top i_dut (.*);
   bpsc_host i_host (.*);
   initial forever #5 clk = ~clk;
   task automatic summarize;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] v, input logic [31:0] e);
      checks++;
      if (v !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, v, e);
      end
   endtask
   task automatic note(input logic [31:0] v, input logic [31:0] e);
      exp_q.push_back(e);
      obs = v;
      ->shot;
      #1;
   endtask
   always @(shot) chk(obs, exp_q.pop_front());
   task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
      i_host.xfer(w, a, d, rd, err);
      if (hung) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [31:0] ctl(logic [1:0] s, logic w, logic i, logic k);
      return 32'(s) | (32'(w) << CTRL_WAKE_EN) | (32'(i) << CTRL_INIT_DONE)
             | (32'(k) << CTRL_CLKRUN_OK);
   endfunction
   initial begin
      void'($urandom(53985));
      card_type = 2'($urandom);
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      cyc(4);
      note({host_clk_en, irq_out, slot_vcc}, 32'h10);
      note({cfg_only, full_decode}, 32'h2);
      rw(1'b0, ADDR_CTRL, 32'h0);
      note(rd, 32'h0);
      rw(1'b0, ADDR_STATUS, 32'h0);
      note(rd, {card_type, 1'b1});
      rw(1'b1, ADDR_SLOT, 32'h5);
      rw(1'b1, ADDR_CTRL, 32'(PST_D1));
      rw(1'b0, ADDR_CTRL, 32'h0);
      note({rd[9], rd[1:0], slot_vcc}, 32'h0);
      rw(1'b0, 8'h0c, 32'h0);
      note(err, 32'h1);
      $display("test uninit done");
      rw(1'b1, ADDR_CTRL, ctl(PST_D0, 0, 1, 1));
      rw(1'b0, ADDR_CTRL, 32'h0);
      note(rd, ctl(PST_D0, 0, 1, 1));
      cyc(1);
      note({host_clk_en, card_clk_en, irq_out}, 32'h1);
      note({cfg_only, full_decode, wake_event}, 32'h2);
      @(posedge clk);
      clkrun_stop <= 1'b0;
      card_irq <= 1'b0;
      socket_change_interrupt <= 1'b1;
      cyc(1);
      note({host_clk_en, card_clk_en, irq_out}, 32'h7);
      sv = 3'($urandom_range(7, 1));
      rw(1'b1, ADDR_SLOT, 32'(sv));
      rw(1'b1, ADDR_CTRL, ctl(PST_D0, 1, 1, 1));
      card_wake <= 1'b1;
      cyc(1);
      note({wake_event, slot_vcc}, {1'b1, sv});
      @(posedge clk);
      card_present <= 1'b0;
      cyc(8);
      note(slot_vcc, 32'h0);
      $display("test active done");
      for (int i = 1; i < 3; i++) begin
         rw(1'b1, ADDR_CTRL, ctl(2'(i), 1, 1, 1));
         rw(1'b0, ADDR_CTRL, 32'h0);
         note(rd[1:0], 32'(i));
         rw(1'b1, ADDR_CTRL, ctl(PST_D0, 1, 1, 1));
         repeat (20000) @(posedge clk);
         rw(1'b0, ADDR_CTRL, 32'h0);
         note(rd, ctl(PST_D0, 1, 1, 1));
      end
      rw(1'b1, ADDR_CTRL, ctl(PST_D3, 1, 1, 1));
      rw(1'b1, ADDR_CTRL, ctl(PST_D0, 1, 0, 1));
      cyc(2);
      note({drivers_off, card_clk_en}, 32'h2);
      // recovery wait scaled down to the warm reset length plus 4 cycles
      repeat (WARM_RST_CYCLES + 4) @(posedge clk);
      rw(1'b0, ADDR_CTRL, 32'h0);
      note(rd, ctl(PST_D0, 1, 0, 0));
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
      rw(1'b0, ADDR_CTRL, 32'h0);
      note(rd, 32'h0);
      $display("test power cycle done");
      summarize();
   end
endmodule
